// ===== verilog/dual_serial_port_channel.sv
// Purpose: one asynchronous serial channel with APB registers
// Assumes: rxd and cts_n synchronous to clk; APB master per AMBA
// Notes:   a second channel is a second instance with its own registers
// Behaviour
// R1 - the channel has its own 64-byte receive and transmit first-in first-out buffers.
// R2 - framing, handshake and rate settings belong to the channel alone.
// R3 - four line modes: plain RS232, in-band flow, hardware flow and RS485 bus.
// R4 - in in-band mode Xoff and Xon received pause and resume sending, and are sent to throttle the peer.
// R5 - in hardware flow mode RTS tells the peer to hold and CTS gates our sending.
// R6 - an even, odd or absent parity bit is added and received parity is checked.
// R7 - five to eight data bits per character.
// R8 - five bits allow one or one and a half stop bits, six to eight allow one or two.
// R9 - bit time is a 2.304 MHz base clock divided by a 16-bit divisor from one upward.
// R10 - rates run from 35 baud to 2.304 megabaud at divisor one.
// R11 - software keeps RS232 rates at or below 115.2 kilobaud.
// R12 - the RS485 mode uses no flow control of either kind.
// R13 - in RS485 mode a direction select drives the bus or releases it to listen.
// R14 - a frame is a low start bit, data least significant first, optional parity, high stop bits.
// R15 - a write to a full transmit buffer is refused and flagged, a read of an empty receive buffer says empty.
//
// Implementation choices: the register addresses and the APB register port.
module dual_serial_port_channel
  import serial_chan_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rts_n,
  output logic             driver_en,
  output logic             irq
);
  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              txd;
    logic              rts_n;
    logic              driver_en;
    logic [1:0]        mode;
    logic [1:0]        parity;
    logic [1:0]        bits;
    logic              stop_long;
    logic              dir;
    logic [15:0]       div;
    logic [IRQ_W-1:0]  isr;
    logic [IRQ_W-1:0]  imr;
    logic [16:0]       tx_acc;
    logic [16:0]       rx_acc;
    tx_state_t         tx_st;
    logic [17:0]       tx_cnt;
    logic [7:0]        tx_sh;
    logic [2:0]        tx_idx;
    logic              tx_par;
    rx_state_t         rx_st;
    logic [17:0]       rx_cnt;
    logic [7:0]        rx_sh;
    logic [2:0]        rx_idx;
    logic              rx_perr;
    logic              paused;
    logic              xoff_sent;
  } chan_state_t;

  chan_state_t r;
  chan_state_t next_r;

  fifo_if tx_f();
  fifo_if rx_f();

  byte_fifo tx_buf (.clk(clk), .nrst(nrst), .f(tx_f)); // R1
  byte_fifo rx_buf (.clk(clk), .nrst(nrst), .f(rx_f)); // R1

  // fractional step of the base clock; one tick per base period
  function automatic logic [17:0] base_step(input logic [16:0] acc);
    logic [17:0] sum;
    sum = {1'h0, acc} + {1'h0, ACC_STEP};
    if (sum >= {1'h0, ACC_WRAP}) begin
      return {1'h1, 17'(sum - {1'h0, ACC_WRAP})};
    end
    return {1'h0, sum[16:0]};
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] bits, input logic odd);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - bits);
    return (^(d & mask)) ^ odd;
  endfunction

  logic        tx_tick;
  logic        rx_tick;
  logic        tx_end;
  logic        rx_end;
  logic [17:0] div18;
  logic [17:0] div_m1;
  logic [17:0] stop_m1;
  logic        par_on;
  logic        par_odd;
  logic        may_send;
  logic        rx_on;
  logic        go;
  logic [7:0]  ch;
  logic [7:0]  rx_data;
  logic        access;
  logic [IRQ_W-1:0] set_irq;
  logic [IRQ_W-1:0] clr_irq;

  assign tx_f.wdata = pwdata[7:0];

  always_comb begin
    next_r       = r;
    tx_f.push    = 1'h0;
    tx_f.pop     = 1'h0;
    rx_f.push    = 1'h0;
    rx_f.pop     = 1'h0;
    set_irq      = '0;
    clr_irq      = '0;
    go           = 1'h0;
    ch           = 8'h00;
    // divisor zero is read as one: the top rate, not a stall
    div18        = (r.div == 16'h0000) ? 18'h00001 : {2'h0, r.div}; // R9
    div_m1       = div18 - 18'h00001;
    // one and a half only with five bits, two otherwise
    if (!r.stop_long) begin
      stop_m1 = div_m1;
    end else if (r.bits == 2'h0) begin
      stop_m1 = div18 + (div18 >> 1) - 18'h00001; // R8
    end else begin
      stop_m1 = (div18 << 1) - 18'h00001; // R8
    end
    par_on       = (r.parity == PAR_EVEN) || (r.parity == PAR_ODD);
    par_odd      = (r.parity == PAR_ODD);
    rx_data      = r.rx_sh >> (2'h3 - r.bits); // R7
    rx_f.wdata   = rx_data;
    {tx_tick, next_r.tx_acc} = base_step(r.tx_acc); // R9
    {rx_tick, next_r.rx_acc} = base_step(r.rx_acc); // R9
    tx_end       = tx_tick && (r.tx_cnt == 18'h00000);
    rx_end       = rx_tick && (r.rx_cnt == 18'h00000);
    if (tx_tick && !tx_end) begin
      next_r.tx_cnt = r.tx_cnt - 18'h00001;
    end
    if (rx_tick && !rx_end) begin
      next_r.rx_cnt = r.rx_cnt - 18'h00001;
    end
    case (r.mode) // R3
      MODE_PLAIN:  may_send = 1'h1;
      MODE_INBAND: may_send = !r.paused; // R4
      MODE_HWFLOW: may_send = !cts_n; // R5
      default:     may_send = r.dir; // R12 R13
    endcase
    rx_on = (r.mode != MODE_BUS) || !r.dir; // R13
    if (r.mode != MODE_INBAND) begin
      next_r.paused    = 1'h0;
      next_r.xoff_sent = 1'h0;
    end

    // transmitter
    case (r.tx_st)
      TX_IDLE: begin
        next_r.txd = 1'h1;
        if (r.mode == MODE_INBAND && !r.xoff_sent && rx_f.level >= XOFF_LEVEL) begin
          ch               = XOFF_CHAR; // R4
          go               = 1'h1;
          next_r.xoff_sent = 1'h1;
        end else if (r.mode == MODE_INBAND && r.xoff_sent && rx_f.level <= XON_LEVEL) begin
          ch               = XON_CHAR; // R4
          go               = 1'h1;
          next_r.xoff_sent = 1'h0;
        end else if (!tx_f.empty && may_send) begin
          ch       = tx_f.rdata;
          go       = 1'h1;
          tx_f.pop = 1'h1;
        end
        if (go) begin
          next_r.tx_st  = TX_START;
          next_r.txd    = 1'h0; // R14
          next_r.tx_sh  = ch;
          next_r.tx_cnt = div_m1;
          next_r.tx_acc = '0;
          next_r.tx_par = parity_of(ch, r.bits, par_odd); // R6
        end
      end
      TX_START: begin
        if (tx_end) begin
          next_r.tx_st  = TX_DATA;
          next_r.txd    = r.tx_sh[0]; // R14
          next_r.tx_idx = 3'h0;
          next_r.tx_cnt = div_m1;
        end
      end
      TX_DATA: begin
        if (tx_end && r.tx_idx == {1'h1, r.bits}) begin // R7
          next_r.tx_st  = par_on ? TX_PARITY : TX_STOP;
          next_r.txd    = par_on ? r.tx_par : 1'h1; // R6
          next_r.tx_cnt = par_on ? div_m1 : stop_m1;
        end else if (tx_end) begin
          next_r.tx_sh  = r.tx_sh >> 1;
          next_r.txd    = r.tx_sh[1]; // R14
          next_r.tx_idx = r.tx_idx + 3'h1;
          next_r.tx_cnt = div_m1;
        end
      end
      TX_PARITY: begin
        if (tx_end) begin
          next_r.tx_st  = TX_STOP;
          next_r.txd    = 1'h1; // R14
          next_r.tx_cnt = stop_m1;
        end
      end
      TX_STOP: begin
        if (tx_end) begin
          next_r.tx_st        = TX_IDLE;
          set_irq[IRQ_TXDONE] = 1'h1;
        end
      end
      default: next_r.tx_st = TX_IDLE;
    endcase

    // receiver samples each bit in its middle
    case (r.rx_st)
      RX_IDLE: begin
        if (rx_on && !rxd) begin
          next_r.rx_st  = RX_START;
          next_r.rx_acc = div18[0] ? ACC_HALF : 17'h00000;
          next_r.rx_cnt = div_m1 >> 1;
        end
      end
      RX_START: begin
        if (rx_end) begin
          // a start bit gone high again was noise
          next_r.rx_st   = rxd ? RX_IDLE : RX_DATA; // R14
          next_r.rx_idx  = 3'h0;
          next_r.rx_sh   = 8'h00;
          next_r.rx_perr = 1'h0;
          next_r.rx_cnt  = div_m1;
        end
      end
      RX_DATA: begin
        if (rx_end) begin
          next_r.rx_sh  = {rxd, r.rx_sh[7:1]}; // R14
          next_r.rx_idx = r.rx_idx + 3'h1;
          next_r.rx_cnt = div_m1;
          if (r.rx_idx == {1'h1, r.bits}) begin
            next_r.rx_st = par_on ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (rx_end) begin
          next_r.rx_perr = (rxd != parity_of(rx_data, r.bits, par_odd)); // R6
          next_r.rx_st   = RX_STOP;
          next_r.rx_cnt  = div_m1;
        end
      end
      RX_STOP: begin
        if (rx_end) begin
          next_r.rx_st       = RX_IDLE;
          set_irq[IRQ_FRAME] = !rxd; // R14
          set_irq[IRQ_PAR]   = r.rx_perr; // R6
          if (r.mode == MODE_INBAND && rx_data == XOFF_CHAR) begin
            next_r.paused = 1'h1; // R4
          end else if (r.mode == MODE_INBAND && rx_data == XON_CHAR) begin
            next_r.paused = 1'h0; // R4
          end else if (rx_f.full) begin
            set_irq[IRQ_OVR] = 1'h1;
          end else begin
            rx_f.push       = 1'h1;
            set_irq[IRQ_RX] = 1'h1;
          end
        end
      end
      default: next_r.rx_st = RX_IDLE;
    endcase

    // register slave: answer one cycle into the access phase
    access         = psel && penable && !r.pready;
    next_r.pready  = access;
    next_r.pslverr = 1'h0;
    if (access) begin
      next_r.prdata = 32'h0000_0000;
      if (paddr == OFS_DATA) begin
        if (pwrite && tx_f.full) begin
          next_r.pslverr      = 1'h1; // R15
          set_irq[IRQ_REFUSE] = 1'h1; // R15
        end else if (pwrite) begin
          tx_f.push = 1'h1;
        end else begin
          next_r.prdata[DATA_EMPTY] = rx_f.empty; // R15
          next_r.prdata[7:0]        = rx_f.empty ? 8'h00 : rx_f.rdata;
          rx_f.pop                  = !rx_f.empty;
        end
      end else if (paddr == OFS_CTRL) begin
        if (pwrite) begin
          next_r.mode      = pwdata[CTRL_MODE +: 2]; // R2 R3
          next_r.parity    = pwdata[CTRL_PAR +: 2];
          next_r.bits      = pwdata[CTRL_BITS +: 2];
          next_r.stop_long = pwdata[CTRL_STOP];
          next_r.dir       = pwdata[CTRL_DIR]; // R13
        end else begin
          next_r.prdata[7:0] = {r.dir, r.stop_long, r.bits, r.parity, r.mode};
        end
      end else if (paddr == OFS_DIV) begin
        if (pwrite) begin
          next_r.div = pwdata[15:0]; // R2 R9 R10
        end else begin
          next_r.prdata[15:0] = r.div;
        end
      end else if (paddr == OFS_STAT) begin
        if (!pwrite) begin
          next_r.prdata[22:0] = {tx_f.level, 1'h0, rx_f.level, 1'h0, r.xoff_sent, r.paused,
                                 (r.tx_st != TX_IDLE), rx_f.empty, rx_f.full, tx_f.empty, tx_f.full};
        end
      end else if (paddr == OFS_ISR) begin
        if (pwrite) begin
          clr_irq = pwdata[IRQ_W-1:0];
        end else begin
          next_r.prdata[IRQ_W-1:0] = r.isr;
        end
      end else if (paddr == OFS_IMR) begin
        if (pwrite) begin
          next_r.imr = pwdata[IRQ_W-1:0];
        end else begin
          next_r.prdata[IRQ_W-1:0] = r.imr;
        end
      end else begin
        next_r.pslverr = 1'h1;
      end
    end

    // a new event beats a clear in the same cycle
    next_r.isr       = (r.isr & ~clr_irq) | set_irq;
    next_r.irq       = |(next_r.isr & next_r.imr);
    next_r.rts_n     = (r.mode == MODE_HWFLOW) && (rx_f.level >= RTS_LEVEL); // R5 R12
    next_r.driver_en = (r.mode == MODE_BUS) && r.dir; // R13
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.txd   <= 1'h1;
      r.bits  <= BITS_RESET;
      r.div   <= DIV_RESET;
      r.tx_st <= TX_IDLE;
      r.rx_st <= RX_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign txd       = r.txd;
  assign rts_n     = r.rts_n;
  assign driver_en = r.driver_en;
  assign irq       = r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_start_low;
    (r.tx_st == TX_IDLE) ##1 (r.tx_st == TX_START) |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // R14

  property p_stop_high;
    (r.tx_st == TX_STOP) |-> txd;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // R14

  property p_cts_gate;
    (r.mode == MODE_HWFLOW) && (r.tx_st == TX_IDLE) && cts_n ##1 (r.tx_st == TX_START) |-> 1'h0;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("sent while peer held cts"); // R5

  property p_pause;
    (r.mode == MODE_INBAND) && r.paused && (r.tx_st == TX_IDLE) ##1 (r.tx_st == TX_START)
      |-> (r.tx_sh == XON_CHAR) || (r.tx_sh == XOFF_CHAR);
  endproperty
  a_pause: assert property (p_pause) else $error("data sent while paused"); // R4

  property p_bus_no_rts;
    (r.mode == MODE_BUS)[*2] |-> !rts_n;
  endproperty
  a_bus_no_rts: assert property (p_bus_no_rts) else $error("flow control active on bus"); // R12

  property p_listen;
    (r.mode == MODE_BUS && !r.dir)[*2] |-> !driver_en && (r.tx_st == TX_IDLE || $past(r.tx_st) != TX_IDLE);
  endproperty
  a_listen: assert property (p_listen) else $error("driver on while listening"); // R13

  property p_refuse;
    access && pwrite && (paddr == OFS_DATA) && tx_f.full |=> pready && pslverr && r.isr[IRQ_REFUSE];
  endproperty
  a_refuse: assert property (p_refuse) else $error("full buffer write not refused"); // R15

  property p_empty_read;
    access && !pwrite && (paddr == OFS_DATA) && rx_f.empty |=> pready && prdata[DATA_EMPTY] && !pslverr;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read not marked"); // R15
endmodule

// ===== verilog/serial_chan_pkg.sv
// Purpose: shared constants and types of the serial channel
// Assumes: 100 MHz system clock, APB register access
// Notes:   one package for the channel top and its byte buffers
package serial_chan_pkg;
  // clock and bit-rate base
  localparam int          CLK_HZ     = 100_000_000;
  localparam int          BASE_HZ    = 2_304_000;
  localparam logic [16:0] ACC_STEP   = 17'(BASE_HZ / 1000);
  localparam logic [16:0] ACC_WRAP   = 17'(CLK_HZ / 1000);
  localparam logic [16:0] ACC_HALF   = 17'(CLK_HZ / 2000);
  // buffers
  localparam int          FIFO_DEPTH = 64;
  localparam int          FIFO_AW    = 6;
  localparam logic [6:0]  FIFO_FULL  = 7'(FIFO_DEPTH);
  localparam logic [6:0]  XOFF_LEVEL = 7'h30;
  localparam logic [6:0]  XON_LEVEL  = 7'h10;
  localparam logic [6:0]  RTS_LEVEL  = 7'h38;
  localparam logic [7:0]  XON_CHAR   = 8'h11;
  localparam logic [7:0]  XOFF_CHAR  = 8'h13;
  // register offsets
  localparam logic [7:0]  OFS_DATA   = 8'h00;
  localparam logic [7:0]  OFS_CTRL   = 8'h04;
  localparam logic [7:0]  OFS_DIV    = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h0C;
  localparam logic [7:0]  OFS_ISR    = 8'h10;
  localparam logic [7:0]  OFS_IMR    = 8'h14;
  // control fields
  localparam int          CTRL_MODE  = 0;
  localparam int          CTRL_PAR   = 2;
  localparam int          CTRL_BITS  = 4;
  localparam int          CTRL_STOP  = 6;
  localparam int          CTRL_DIR   = 7;
  localparam int          DATA_EMPTY = 8;
  localparam logic [1:0]  BITS_RESET = 2'h3;
  localparam logic [15:0] DIV_RESET  = 16'h00F0;
  // interrupt bits
  localparam int          IRQ_RX     = 0;
  localparam int          IRQ_TXDONE = 1;
  localparam int          IRQ_PAR    = 2;
  localparam int          IRQ_FRAME  = 3;
  localparam int          IRQ_OVR    = 4;
  localparam int          IRQ_REFUSE = 5;
  localparam int          IRQ_W      = 6;

  typedef enum logic [1:0] {MODE_PLAIN = 2'h0, MODE_INBAND = 2'h1, MODE_HWFLOW = 2'h2, MODE_BUS = 2'h3} line_mode_t;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_t;
  typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PARITY = 5'h08,
                            TX_STOP = 5'h10} tx_state_t;
  typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PARITY = 5'h08,
                            RX_STOP = 5'h10} rx_state_t;
endpackage

// ===== verilog/fifo_if.sv
// Purpose: push/pop carrier between the channel and a byte buffer
// Assumes: both sides on the system clock
// Notes:   store side owns the flags
interface fifo_if;
  logic       push;
  logic [7:0] wdata;
  logic       full;
  logic       pop;
  logic [7:0] rdata;
  logic       empty;
  logic [6:0] level;
  modport store (input push, input wdata, input pop, output full, output rdata, output empty, output level);
  modport user  (output push, output wdata, output pop, input full, input rdata, input empty, input level);
endinterface

// ===== verilog/byte_fifo.sv
// Purpose: 64-byte first-in first-out byte buffer
// Assumes: caller checks full before push and empty before pop
// Notes:   push on full and pop on empty are ignored
module byte_fifo
  import serial_chan_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  fifo_if.store    f
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [FIFO_AW-1:0]         wr;
    logic [FIFO_AW-1:0]         rd;
    logic [6:0]                 level;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t next_r;
  logic        do_push;
  logic        do_pop;

  assign f.full  = (r.level == FIFO_FULL);
  assign f.empty = (r.level == 7'h00);
  assign f.rdata = r.mem[r.rd];
  assign f.level = r.level;

  always_comb begin
    next_r  = r;
    do_push = f.push && (r.level != FIFO_FULL);
    do_pop  = f.pop && (r.level != 7'h00);
    if (do_push) begin
      next_r.mem[r.wr] = f.wdata;
      next_r.wr        = r.wr + 6'h01;
    end
    if (do_pop) begin
      next_r.rd = r.rd + 6'h01;
    end
    if (do_push && !do_pop) begin
      next_r.level = r.level + 7'h01;
    end else if (do_pop && !do_push) begin
      next_r.level = r.level - 7'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_depth_bound;
    (r.level == FIFO_FULL) && f.push && !f.pop |=> (r.level == FIFO_FULL) && $stable(r.wr);
  endproperty
  a_depth_bound: assert property (p_depth_bound) else $error("push into full buffer was stored"); // R1
endmodule

// ===== testbench/remote_station.sv
// Purpose: remote serial station on the far side of the channel
// Assumes: bit time given in whole clk cycles, set by the bench
// Notes:   line idles high; only the first stop bit is sampled
module remote_station (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic rts_n,
  output logic      rxd,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clk = 43;
  int         nbits   = 8;
  int         par     = 0;
  logic [9:0] got[$];

  initial begin
    rxd   = 1'b1;
    cts_n = 1'b1;
  end

  // mid-bit sampling; half-tick drift per bit is well inside the margin
  always begin
    logic [9:0] f;
    @(negedge txd);
    f = '0;
    repeat (bit_clk / 2) @(posedge clk);
    for (int i = 0; i < nbits + int'(par != 0) + 1; i++) begin
      repeat (bit_clk) @(posedge clk);
      f[i] = txd;
    end
    got.push_back(f);
  end

  task automatic drive(input logic v);
    rxd <= v;
    repeat (bit_clk) @(posedge clk);
  endtask

  // flip corrupts the parity bit on purpose
  task automatic send(input logic [7:0] d, input logic flip);
    @(posedge clk);
    drive(1'b0);
    for (int i = 0; i < nbits; i++) drive(d[i]);
    if (par != 0) drive(^d ^ (par == 2) ^ flip);
    drive(1'b1);
  endtask
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench of one serial channel
// Assumes: apb answers within 50 cycles
// Notes:   fast frames use the bus mode; in-band and hardware flow rs232 kept at 115.2k
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_chan_pkg::*;
  logic        clk, nrst, psel, penable, pwrite;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rxd, cts_n, txd, rts_n, driver_en, irq;
  logic [33:0] apb_q[$];
  logic [9:0]  tx_q[$];
  int          mismatches, samples_checked, frames_seen, n;

  always #5 clk = ~clk;

  dual_serial_port_channel dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .driver_en(driver_en), .irq(irq));
  remote_station peer_u (.clk(clk), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic cd);
    apb_q.push_back({cd, e});
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // pready is looked at on the rising edge; release only after it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0}, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e}, 1'b1);
  endtask

  function automatic logic [9:0] frame(input logic [7:0] d, input int nb, input int pr);
    logic [9:0] f;
    f = 10'(d & 8'((1 << nb) - 1));
    if (pr != 0) f[nb] = ^f ^ (pr == 2);
    f[nb + int'(pr != 0)] = 1'b1;
    return f;
  endfunction

  task automatic put(input logic [7:0] d);
    wr(OFS_DATA, {24'h0, d}, 1'b0);
    tx_q.push_back(frame(d, peer_u.nbits, peer_u.par));
  endtask

  task automatic wait_frames(input int k);
    n = 0;
    while (frames_seen < k && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (frames_seen < k) mismatches++;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // results are matched against the oldest note when they appear
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      check("pslverr", 32'(pslverr), 32'(apb_q[0][32]));
      if (apb_q[0][33]) check("prdata", prdata, apb_q[0][31:0]);
      void'(apb_q.pop_front());
    end
    if (peer_u.got.size() > 0) begin
      check("frame", {22'h0, peer_u.got.pop_front()}, {22'h0, tx_q.pop_front()});
      frames_seen++;
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    clk = 0;
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    mismatches = 0;
    samples_checked = 0;
    frames_seen = 0;
    n = $urandom(32'h293D);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    check("reset outputs", {26'h0, pready, pslverr, txd, rts_n, driver_en, irq}, 32'h8);
    rd(OFS_CTRL, 32'h30);
    rd(OFS_DIV, 32'hF0);
    rd(OFS_STAT, 32'h0A);
    rd(OFS_DATA, 32'h100);
    apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000, 1'b1);
    // bus mode first, so the top rate never meets an rs232 mode
    wr(OFS_CTRL, 32'h33, 1'b0);
    wr(OFS_DIV, 32'h1, 1'b0);
    settle();
    check("driver_en", 32'(driver_en), 32'h0);
    wr(OFS_ISR, 32'h3F, 1'b0);
    wr(OFS_IMR, 32'h01, 1'b0);
    // second round: even parity with a corrupted parity bit
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      peer_u.send(b, 1'(k));
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      rd(OFS_ISR, k ? 32'h05 : 32'h01);
      rd(OFS_DATA, {24'h0, b});
      wr(OFS_IMR, 32'h0, 1'b0);
      settle();
      check("irq masked", 32'(irq), 32'h0);
      wr(OFS_IMR, 32'h1, 1'b0);
      settle();
      check("irq", 32'(irq), 32'h1);
      wr(OFS_ISR, 32'h3F, 1'b0);
      settle();
      check("irq cleared", 32'(irq), 32'h0);
      wr(OFS_CTRL, 32'h37, 1'b0);
      peer_u.par = 1;
    end
    wr(OFS_CTRL, 32'h33, 1'b0);
    peer_u.par = 0;
    for (int k = 0; k < 64; k++) put(8'($urandom));
    wr(OFS_DATA, 32'hA5, 1'b1);
    rd(OFS_STAT, 32'h0040_0009);
    rd(OFS_ISR, 32'h20);
    wr(OFS_CTRL, 32'hB3, 1'b0);
    settle();
    check("driver_en", 32'(driver_en), 32'h1);
    wait_frames(64);
    for (int nb = 5; nb <= 8; nb++) begin
      for (int pr = 0; pr < 3; pr++) begin
        peer_u.nbits = nb;
        peer_u.par = pr;
        wr(OFS_CTRL, 32'(8'h83 | (pr << 2) | ((nb - 5) << 4) | ((nb & 1) << 6)), 1'b0);
        put(8'($urandom));
        wait_frames(frames_seen + 1);
      end
    end
    peer_u.nbits = 8;
    peer_u.par = 0;
    peer_u.bit_clk = 868;
    wr(OFS_DIV, 32'h14, 1'b0);
    // in-band flow: xoff holds the queued byte until xon arrives
    wr(OFS_CTRL, 32'h31, 1'b0);
    peer_u.send(XOFF_CHAR, 1'b0);
    put(8'($urandom));
    rd(OFS_STAT, 32'h0001_0028);
    peer_u.send(XON_CHAR, 1'b0);
    wait_frames(77);
    wr(OFS_CTRL, 32'h32, 1'b0);
    put(8'($urandom));
    repeat (2000) @(posedge clk);
    check("frames held", 32'(frames_seen), 32'h4D);
    check("txd held", 32'(txd), 32'h1);
    check("rts_n", 32'(rts_n), 32'h0);
    peer_u.cts_n <= 1'b0;
    wait_frames(78);
    tally_and_finish();
  end
endmodule
